// File: design/iols_pkg.sv
// Notes on behaviour
// - drive 18 leds: module power, module fault, eight red, eight amber
// - after reset light power and fault; fault stays lit through address display
// - red leds turn on one by one, channel 1 up to 8
// - after channel 8 red is on, reds turn off one by one, 1 to 8
// - amber leds then get the same on sweep and off sweep
// - after lamp test, address switch n shows on red led n when on
// - address pattern is held for two seconds
// - end of address display turns the module fault led off
// - after power-up go unconfigured or normal by configuration valid
// - unconfigured: all amber leds blink together at one rate
// - supervised channel fault lights its amber led and sets status flag
// - failed positive or negative driver test lights amber and sets flag
// - green power led is on while powered
// - module fault led steady on when disabled, replace needed or watchdog fail
// - module fault led blinks once in power-up, no other fault shown then
// - discrete variant: red steady while input closed or output active
// - amber blinks for low power or bad config; discrete: steady for fault
// - relay variant: red on while active; amber only blinks
package iols_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned ADDR_SHOW_MS = 2000;
    localparam int unsigned ADDR_SHOW_CYC = CLK_HZ / 1000 * ADDR_SHOW_MS;
    localparam int unsigned STEP_MS = 100;
    localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned NCH = 8;
    // axi register byte addresses
    localparam logic [7:0] ADDR_LED = 8'h00;
    localparam logic [7:0] ADDR_CHST = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // irq status bit positions
    localparam int unsigned IRQ_SUP = 0;
    localparam int unsigned IRQ_DRV = 1;
    localparam int unsigned IRQ_MOD = 2;
    localparam int unsigned IRQ_RUN = 3;

    typedef enum logic [2:0] {
        IOLS_RED_ON = 3'h0,
        IOLS_RED_OFF = 3'h1,
        IOLS_AMB_ON = 3'h2,
        IOLS_AMB_OFF = 3'h3,
        IOLS_ADDR = 3'h4,
        IOLS_RUN = 3'h5
    } iols_phase_t;

    typedef struct packed {
        logic power;
        logic fault;
        logic [NCH-1:0] red;
        logic [NCH-1:0] amber;
    } iols_leds_t;

    typedef struct packed {
        logic [NCH-1:0] active;
        logic [NCH-1:0] sup_en;
        logic [NCH-1:0] sup_fault;
        logic [NCH-1:0] drv_pos_fail;
        logic [NCH-1:0] drv_neg_fail;
        logic [NCH-1:0] low_power;
        logic [NCH-1:0] ch_cfg_bad;
    } iols_chan_t;
endpackage : iols_pkg

// File: design/iols_top.sv
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iols_top import iols_pkg::*; #(
    parameter int unsigned STEP_CYCLES = STEP_CYC,
    parameter int unsigned ADDR_CYCLES = ADDR_SHOW_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and status inputs
    input wire logic [NCH-1:0] addr_sw,
    input wire logic cfg_valid,
    input wire logic mod_disabled,
    input wire logic wdog_fail,
    input wire iols_chan_t chan_in,
    // leds, channel fault flags and interrupt
    output iols_leds_t leds,
    output logic [NCH-1:0] chan_fault_flag,
    output logic irq,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int unsigned SW = 3 + 7 * NCH + NCH;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {addr_sw, cfg_valid, mod_disabled, wdog_fail, chan_in};
            sync2 <= sync1;
        end
    end
    logic [NCH-1:0] sw_s;
    logic cfg_s;
    logic dis_s;
    logic wd_s;
    iols_chan_t ch_s;
    assign {sw_s, cfg_s, dis_s, wd_s, ch_s} = sync2;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // ctrl bit0 relay variant, bit1 software fault force
    logic [2:0] ctrl;
    wire relay_mode = ctrl[0];

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    iols_phase_t phase;
    logic [31:0] tmr;
    logic [2:0] idx;
    wire tick = (tmr == STEP_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= IOLS_RED_ON;
            tmr <= '0;
            idx <= '0;
        end else begin
            unique case (phase)
                IOLS_RED_ON, IOLS_RED_OFF, IOLS_AMB_ON, IOLS_AMB_OFF: begin
                    tmr <= tick ? '0 : tmr + 32'h1;
                    if (tick) begin
                        idx <= idx + 3'h1;
                        if (idx == 3'h7) begin
                            phase <= iols_phase_t'(phase + 3'h1);
                        end
                    end
                end
                IOLS_ADDR: begin
                    tmr <= tmr + 32'h1;
                    if (tmr == ADDR_CYCLES - 1) begin
                        phase <= IOLS_RUN;
                        tmr <= '0;
                    end
                end
                IOLS_RUN: begin
                    tmr <= '0;
                end
                default: begin
                    phase <= IOLS_RED_ON;
                end
            endcase
        end
    end

    // ----------------------------------------
    // blink generator
    // ----------------------------------------
    logic [31:0] bcnt;
    logic blink;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcnt <= '0;
            blink <= 1'b0;
        end else if (bcnt == BLINK_CYCLES - 1) begin
            bcnt <= '0;
            blink <= ~blink;
        end else begin
            bcnt <= bcnt + 32'h1;
        end
    end

    // ----------------------------------------
    // led drive
    // ----------------------------------------
    function automatic logic [NCH-1:0] upto(input logic [2:0] n);
        upto = NCH'((16'h2 << n) - 16'h1);
    endfunction : upto

    wire [NCH-1:0] sup_flt = ch_s.sup_en & ch_s.sup_fault;
    wire [NCH-1:0] drv_flt = ch_s.drv_pos_fail | ch_s.drv_neg_fail;
    wire [NCH-1:0] ch_flt = sup_flt | drv_flt;
    wire [NCH-1:0] ch_blink = ch_s.low_power | ch_s.ch_cfg_bad;
    wire mod_flt = dis_s | wd_s | ctrl[1];
    iols_leds_t next_leds;
    always_comb begin
        next_leds.power = 1'b1;
        next_leds.fault = 1'b1;
        next_leds.red = '0;
        next_leds.amber = '0;
        unique case (phase)
            IOLS_RED_ON: next_leds.red = upto(idx) & {NCH{tick}} | upto(idx) >> 1;
            IOLS_RED_OFF: next_leds.red = ~upto(idx) | {NCH{~tick}} & upto(idx) & ~(upto(idx) >> 1);
            IOLS_AMB_ON: next_leds.amber = upto(idx) & {NCH{tick}} | upto(idx) >> 1;
            IOLS_AMB_OFF: next_leds.amber = ~upto(idx) | {NCH{~tick}} & upto(idx) & ~(upto(idx) >> 1);
            IOLS_ADDR: next_leds.red = sw_s;
            IOLS_RUN: begin
                next_leds.fault = mod_flt;
                if (!cfg_s) begin
                    next_leds.amber = {NCH{blink}};
                end else begin
                    next_leds.red = ch_s.active;
                    next_leds.amber = ch_blink & {NCH{blink}};
                    if (!relay_mode) begin
                        next_leds.amber = next_leds.amber | ch_flt;
                    end
                end
            end
            default: ;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leds <= '{power: 1'b1, fault: 1'b1, red: '0, amber: '0};
            chan_fault_flag <= '0;
        end else begin
            leds <= next_leds;
            chan_fault_flag <= (phase == IOLS_RUN) ? ch_flt : '0;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [3:0] irq_ev;
    logic [NCH-1:0] ch_flt_d;
    logic mod_flt_d;
    logic run_d;
    logic rd_st;
    assign rd_st = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_IRQ_ST);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_flt_d <= '0;
            mod_flt_d <= 1'b0;
            run_d <= 1'b0;
        end else begin
            ch_flt_d <= ch_flt;
            mod_flt_d <= mod_flt;
            run_d <= (phase == IOLS_RUN);
        end
    end
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_SUP] = |(sup_flt & ~ch_flt_d);
        irq_ev[IRQ_DRV] = |(drv_flt & ~ch_flt_d);
        irq_ev[IRQ_MOD] = mod_flt & ~mod_flt_d;
        irq_ev[IRQ_RUN] = (phase == IOLS_RUN) & ~run_d;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st <= '0;
            irq <= 1'b0;
        end else begin
            irq_st <= (rd_st ? 4'h0 : irq_st) | irq_ev;
            irq <= |(((rd_st ? 4'h0 : irq_st) | irq_ev) & irq_mask);
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_hit;
    logic w_hit;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_hit <= 1'b0;
            w_hit <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            irq_mask <= '0;
            ctrl <= CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hit <= 1'b1;
                aw_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hit <= 1'b1;
                w_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
                s_axi_wready <= 1'b0;
            end
            if (aw_hit && w_hit && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                if (aw_q == ADDR_IRQ_MASK) begin
                    irq_mask <= w_q[3:0];
                end else if (aw_q == ADDR_CTRL) begin
                    ctrl <= w_q[2:0];
                end else if (aw_q != ADDR_LED && aw_q != ADDR_CHST && aw_q != ADDR_IRQ_ST) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hit <= 1'b0;
                w_hit <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_LED: s_axi_rdata <= {11'h0, phase, leds};
                    ADDR_CHST: s_axi_rdata <= {16'h0, sw_s, chan_fault_flag};
                    ADDR_IRQ_ST: s_axi_rdata <= {28'h0, irq_st};
                    ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
                    ADDR_CTRL: s_axi_rdata <= {29'h0, ctrl};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_power_on;
        @(posedge aclk) disable iff (!aresetn) leds.power;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power led off");
    property p_fault_powerup;
        @(posedge aclk) disable iff (!aresetn) (phase != IOLS_RUN) |=> leds.fault;
    endproperty
    a_fault_powerup: assert property (p_fault_powerup) else $error("fault off in power-up");
    property p_addr_show;
        @(posedge aclk) disable iff (!aresetn) (phase == IOLS_ADDR) |=> (leds.red == sw_s || phase == IOLS_RUN);
    endproperty
    a_addr_show: assert property (p_addr_show) else $error("address not shown");
    property p_red_mono;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RED_ON && !tick) |=> ($past(leds.red) == leds.red || $past(phase) != IOLS_RED_ON);
    endproperty
    a_red_mono: assert property (p_red_mono) else $error("red sweep moved off tick");
    property p_fault_end;
        @(posedge aclk) disable iff (!aresetn) (phase == IOLS_RUN && !mod_flt) |=> !leds.fault;
    endproperty
    a_fault_end: assert property (p_fault_end) else $error("fault led stuck");
    property p_mod_fault;
        @(posedge aclk) disable iff (!aresetn) (phase == IOLS_RUN && wd_s) |=> leds.fault;
    endproperty
    a_mod_fault: assert property (p_mod_fault) else $error("watchdog fault not shown");
    property p_unconf;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && !cfg_s) |=> (leds.amber == {NCH{$past(blink)}});
    endproperty
    a_unconf: assert property (p_unconf) else $error("unconfigured blink wrong");
    property p_chflag;
        @(posedge aclk) disable iff (!aresetn) (phase == IOLS_RUN) |=> chan_fault_flag == $past(ch_flt);
    endproperty
    a_chflag: assert property (p_chflag) else $error("channel flag wrong");
    // address display length counter
    logic [31:0] addr_len;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_len <= '0;
        end else begin
            addr_len <= (phase == IOLS_ADDR) ? addr_len + 32'h1 : 32'h0;
        end
    end
    property p_addr_len;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_ADDR) |-> (addr_len < ADDR_CYCLES);
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("address shown too long");
    property p_addr_end;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && $past(phase) == IOLS_ADDR) |->
                ($past(addr_len) == ADDR_CYCLES - 1);
    endproperty
    a_addr_end: assert property (p_addr_end) else $error("address shown too short");
    property p_red_off;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RED_OFF) |=>
                ((leds.red & ~$past(leds.red)) == '0 && leds.amber == '0);
    endproperty
    a_red_off: assert property (p_red_off) else $error("red lit in off sweep");
    property p_amb_on;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_AMB_ON) |=>
                (leds.red == '0 && ($past(leds.amber) & ~leds.amber) == '0);
    endproperty
    a_amb_on: assert property (p_amb_on) else $error("amber on sweep wrong");
    property p_amb_off;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_AMB_OFF) |=>
                (leds.red == '0 && (leds.amber & ~$past(leds.amber)) == '0);
    endproperty
    a_amb_off: assert property (p_amb_off) else $error("amber off sweep wrong");
    property p_red_run;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && cfg_s) |=> (leds.red == $past(ch_s.active));
    endproperty
    a_red_run: assert property (p_red_run) else $error("red not active state");
    property p_sup_amber;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && cfg_s && !relay_mode) |=>
                ((leds.amber & $past(sup_flt)) == $past(sup_flt));
    endproperty
    a_sup_amber: assert property (p_sup_amber) else $error("supervision fault not lit");
    property p_drv_amber;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && cfg_s && !relay_mode) |=>
                ((leds.amber & $past(drv_flt)) == $past(drv_flt));
    endproperty
    a_drv_amber: assert property (p_drv_amber) else $error("driver fault not lit");
    property p_relay_amber;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && cfg_s && relay_mode) |=>
                ((leds.amber & ~$past(ch_blink)) == '0);
    endproperty
    a_relay_amber: assert property (p_relay_amber) else $error("relay amber steady");
    property p_ch_blink;
        @(posedge aclk) disable iff (!aresetn)
            (phase == IOLS_RUN && cfg_s) |=>
                ((leds.amber & ~$past(ch_flt)) ==
                    ($past(ch_blink) & ~$past(ch_flt) & {NCH{$past(blink)}}));
    endproperty
    a_ch_blink: assert property (p_ch_blink) else $error("channel blink wrong");
endmodule : iols_top

// File: test/iols_panel.sv
`timescale 1ns/1ps
// ---------------------------------------------
// front panel: dip switches and led observer
// ---------------------------------------------
module iols_panel import iols_pkg::*; #(
    parameter logic [NCH-1:0] SW = 8'hA5
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // panel
    input wire iols_leds_t leds,
    output logic [NCH-1:0] addr_sw
);
    iols_leds_t seen[$];
    int dur[$];
    // switches are set before power-up and never move
    assign addr_sw = SW;
    // log each change of the 18 leds and how long it stood
    always @(posedge aclk) begin
        if (aresetn) begin
            if (seen.size() == 0 || leds !== seen[seen.size()-1]) begin
                seen.push_back(leds);
                dur.push_back(1);
            end else begin
                dur[dur.size()-1] = dur[dur.size()-1] + 1;
            end
        end
    end
endmodule : iols_panel

// File: test/test_io_module_led_selftest_status.sv
`timescale 1ns/1ps
module test_io_module_led_selftest_status import iols_pkg::*;;
    localparam int STEP = 4;
    localparam int ADDR = 10;
    localparam logic [7:0] SW = 8'hA5;
    logic aclk, aresetn, cfg_valid, mod_disabled, wdog_fail, irq;
    logic [7:0] addr_sw, chan_fault_flag, s_axi_awaddr, s_axi_araddr, sa_on, sa_all, ex;
    iols_chan_t chan_in;
    iols_leds_t leds;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors, compares, i, j, k, n;
    iols_top #(.STEP_CYCLES(STEP), .ADDR_CYCLES(ADDR), .BLINK_CYCLES(3)) uut (.aclk(aclk),
        .aresetn(aresetn), .addr_sw(addr_sw), .cfg_valid(cfg_valid),
        .mod_disabled(mod_disabled), .wdog_fail(wdog_fail), .chan_in(chan_in), .leds(leds),
        .chan_fault_flag(chan_fault_flag), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    iols_panel #(.SW(SW)) panel (.aclk(aclk), .aresetn(aresetn), .leds(leds),
        .addr_sw(addr_sw));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) done = 1'b1;
        end
        s_axi_bready <= 1'b0;
        chk(32'({s_axi_awvalid, s_axi_wvalid}), 32'h0);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axi_write
    task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) done = 1'b1;
        end
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_arvalid), 32'h0);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : axi_read
    // amber bits ever on, and bits on in every sample
    task sample(input int c);
        sa_on = 8'h00;
        sa_all = 8'hFF;
        repeat (c) begin
            @(posedge aclk);
            sa_on = sa_on | leds.amber;
            sa_all = sa_all & leds.amber;
        end
    endtask : sample
    task fault_src(input int s, input logic v);
        if (s == 0) mod_disabled <= v;
        else if (s == 1) wdog_fail <= v;
        else axi_write(ADDR_CTRL, {30'h0, v, 1'b0}, RESP_OKAY);
    endtask : fault_src
    task wrap_up;
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // ---------------------------------------------
    // clock, watchdog, tests
    // ---------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        wrap_up;
    end
    initial begin
        {aresetn, cfg_valid, mod_disabled, wdog_fail, chan_in} <= '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} <= '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
        errors = 0;
        compares = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        n = 0;
        while (leds.fault !== 1'b0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        repeat (4) @(posedge aclk);
        j = 0;
        for (i = 0; i < panel.seen.size(); i++) begin
            if (panel.seen[i].red !== 8'h00 || panel.seen[i].amber !== 8'h00) begin
                if (j < 30) begin
                    ex = j < 8 ? 8'hFF >> (7 - j) : j < 15 ? 8'hFF << (j - 7) :
                         j < 23 ? 8'hFF >> (22 - j) : 8'hFF << (j - 22);
                    chk(32'(panel.seen[i]), j < 15 ? {14'h0, 2'b11, ex, 8'h00} :
                        {14'h0, 2'b11, 8'h00, ex});
                end
                if (j == 30) chk(32'(panel.seen[i]), {14'h0, 2'b11, SW, 8'h00});
                if (j == 30) chk(32'(panel.dur[i]), ADDR);
                if ((j >= 1 && j <= 6) || (j >= 16 && j <= 21)) chk(panel.dur[i], STEP);
                if (j == 31) chk(32'(panel.seen[i].fault), 32'h0);
                j++;
            end
        end
        chk(32'(j > 31), 32'h1);
        axi_write(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        axi_write(ADDR_IRQ_MASK, 32'hF, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        axi_read(ADDR_IRQ_ST, 32'h8, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        axi_read(ADDR_IRQ_ST, 32'h0, RESP_OKAY);
        sample(12);
        chk({sa_on, sa_all, 14'h0, leds.power, leds.fault}, 32'hFF000002);
        cfg_valid <= 1'b1;
        chan_in.active <= 8'h3C;
        chan_in.sup_en <= 8'h01;
        chan_in.sup_fault <= 8'h03;
        chan_in.drv_pos_fail <= 8'h10;
        chan_in.drv_neg_fail <= 8'h40;
        repeat (6) @(posedge aclk);
        sample(12);
        chk({sa_on, sa_all, leds.red, chan_fault_flag}, 32'h51513C51);
        axi_read(ADDR_IRQ_ST, 32'h3, RESP_OKAY);
        axi_read(ADDR_CHST, {16'h0, SW, 8'h51}, RESP_OKAY);
        chan_in.low_power <= 8'h80;
        repeat (6) @(posedge aclk);
        sample(12);
        chk({sa_on, sa_all}, 32'hD151);
        axi_write(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (6) @(posedge aclk);
        sample(12);
        chk({sa_all, leds.red}, 32'h003C);
        axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
        for (k = 0; k < 3; k++) begin
            fault_src(k, 1'b1);
            repeat (6) @(posedge aclk);
            chk(32'(leds.fault), 32'h1);
            fault_src(k, 1'b0);
            repeat (6) @(posedge aclk);
            chk(32'(leds.fault), 32'h0);
        end
        axi_read(ADDR_IRQ_ST, 32'h4, RESP_OKAY);
        axi_read(ADDR_IRQ_MASK, 32'hF, RESP_OKAY);
        axi_read(8'h20, 32'h0, RESP_SLVERR);
        axi_write(8'h24, 32'h1, RESP_SLVERR);
        chk(32'(leds.power), 32'h1);
        wrap_up;
    end
endmodule : test_io_module_led_selftest_status
